// File: core/esm_consts.svh
// Register offsets, field positions, latencies and probe codes of the exposure status block
`ifndef ESM_CONSTS_SVH
`define ESM_CONSTS_SVH

// Register indices on the internal configuration port
`define ESM_ADDR_SAMPLE_COUNT 9'h0b8
`define ESM_ADDR_MEAN_LEVEL 9'h0ba
`define ESM_ADDR_LOOP_EXPOSURE 9'h0bb
`define ESM_ADDR_LOOP_AMP 9'h0bc
`define ESM_ADDR_PROBE_CTRL 9'h0c0
`define ESM_ADDR_GAIN_CTRL 9'h0cc
`define ESM_ADDR_APP_STEP 9'h0d0
`define ESM_ADDR_APP_CLEAR 9'h0d1
`define ESM_ADDR_APP_EXPOSURE 9'h0d2
`define ESM_ADDR_APP_KNEE2 9'h0d3
`define ESM_ADDR_APP_KNEE3 9'h0d4
`define ESM_ADDR_APP_AMP 9'h0d5
`define ESM_ADDR_APP_FINE 9'h0d6

// Field positions
`define ESM_PROBE_SEL_LSB 11
`define ESM_GAIN_COMP_BIT 13
`define ESM_KNEE2_EN_BIT 12
`define ESM_KNEE3_EN_BIT 13

// Frame-start counts from request to effect
`define ESM_EXP_LATENCY 2'h2
`define ESM_GAIN_LATENCY 2'h1

// Probe selection codes
`define ESM_PROBE_OFF 3'h0
`define ESM_PROBE_INT_ROW 3'h1
`define ESM_PROBE_INT_KNEE 3'h2
`define ESM_PROBE_COL_BLACK 3'h3
`define ESM_PROBE_FRAME_ROW 3'h4
`define ESM_PROBE_LINE_ROW 3'h5
`define ESM_PROBE_ROW_COL 3'h6
`define ESM_PROBE_COL_SPLIT 3'h7

`endif

// File: core/esm_pkg.sv
// Types shared by the exposure status and monitor block
package esm_pkg;

    // Result of one exposure loop evaluation
    typedef struct packed {
        logic [15:0] exposure;
        logic [1:0] first_amp;
        logic [1:0] second_amp;
        logic [11:0] fine_gain;
    } esm_loop_s;

    // Sequencer settings that are not steered by the loop
    typedef struct packed {
        logic [15:0] step_scaler;
        logic [15:0] array_clear_time;
        logic [15:0] second_knee_exposure;
        logic [15:0] third_knee_exposure;
        logic two_knee_integration;
        logic three_knee_integration;
    } esm_seq_cfg_s;

    // Sequencer timing indications for the probe outputs
    typedef struct packed {
        logic integration_active;
        logic row_overhead_window;
        logic frame_overhead_window;
        logic col_readout_start;
        logic black_line;
        logic frame_start_ind;
        logic row_overhead_start;
        logic first_line;
    } esm_seq_ind_s;

endpackage

// File: core/esm_status.sv
// Exposure loop status registers, request cadence and probe output selector
//
// How it works
// - Loop evaluates and requests only every other frame
// - Compensation bit delays gain to exposure latency
// - Loop status refreshes when request is issued
// - Applied status refreshes when values take effect
// - Report 16-bit count of statistics pixels
// - Report 10-bit mean illumination of frame
// - Loop exposure and amp settings, frame end
// - Loop fine gain, 5.7 unsigned, frame end
// - Applied step scaler, global shutter only
// - Applied array clear time, global shutter only
// - Applied exposure refreshed on effect
// - Knee exposures refreshed on effect, loop-independent
// - Applied amp stages at bits 0 and 5
// - Applied fine gain refreshed on effect
// - Knee configurations refreshed on effect, loop-independent
// - Three-bit selector routes indications to probes
// - Code 0 low; code 1 integration, row overhead
// - Code 2 integration, knee frame overhead
// - Code 3 column start, black line window
// - Codes 4/5 frame start or first line, row start
// - Code 6 row overhead, column start
// - Code 7 column start split black/image
`timescale 1ns/1ps
`default_nettype none
`include "esm_consts.svh"

module esm_status
    import esm_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Frame timing from the sequencer
    input wire logic frame_start,
    input wire logic frame_end,
    input wire logic global_shutter,
    // Statistics and loop results
    input wire logic [15:0] sample_count,
    input wire logic [9:0] mean_level,
    input wire esm_loop_s loop_result,
    // Sequencer settings and indications
    input wire esm_seq_cfg_s seq_cfg,
    input wire esm_seq_ind_s seq_ind,
    // Internal configuration register port
    input wire logic [8:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // Request towards the sequencer
    output logic exp_request,
    output esm_loop_s request_values,
    // Monitor pins
    output logic probe_out_a,
    output logic probe_out_b
);

    typedef struct packed {
        logic parity;
        logic [15:0] sample_count;
        logic [9:0] mean_level;
        esm_loop_s loop;
        esm_loop_s pend;
        logic [1:0] exp_wait;
        logic [1:0] gain_wait;
        logic [15:0] app_exposure;
        logic [1:0] app_first_amp;
        logic [1:0] app_second_amp;
        logic [11:0] app_fine;
        logic [15:0] app_step;
        logic [15:0] app_clear;
        logic [15:0] app_knee2;
        logic [15:0] app_knee3;
        logic app_knee2_en;
        logic app_knee3_en;
        logic [2:0] probe_sel;
        logic gain_comp;
        logic req;
        logic [15:0] rdata;
        logic rvalid;
        logic probe_a;
        logic probe_b;
    } esm_state_s;

    esm_state_s s;
    esm_state_s next_s;
    logic eval_now;
    logic [15:0] read_value;

    // Evaluation happens on every second frame end
    assign eval_now = frame_end && s.parity;

    // Read data selection; unmapped offsets read as zero
    always_comb
    begin
        read_value = 16'h0000;
        case (reg_addr)
            `ESM_ADDR_SAMPLE_COUNT: read_value = s.sample_count;
            `ESM_ADDR_MEAN_LEVEL: read_value = {6'h00, s.mean_level};
            `ESM_ADDR_LOOP_EXPOSURE: read_value = s.loop.exposure;
            `ESM_ADDR_LOOP_AMP: read_value = {s.loop.fine_gain, s.loop.second_amp, s.loop.first_amp};
            `ESM_ADDR_PROBE_CTRL: read_value = {2'h0, s.probe_sel, 11'h000};
            `ESM_ADDR_GAIN_CTRL: read_value = {2'h0, s.gain_comp, 13'h0000};
            `ESM_ADDR_APP_STEP: read_value = s.app_step;
            `ESM_ADDR_APP_CLEAR: read_value = s.app_clear;
            `ESM_ADDR_APP_EXPOSURE: read_value = s.app_exposure;
            `ESM_ADDR_APP_KNEE2: read_value = s.app_knee2;
            `ESM_ADDR_APP_KNEE3: read_value = s.app_knee3;
            `ESM_ADDR_APP_AMP: read_value = {3'h0, 6'h00, s.app_second_amp, 3'h0, s.app_first_amp};
            `ESM_ADDR_APP_FINE: read_value = {2'h0, s.app_knee3_en, s.app_knee2_en, s.app_fine};
            default: read_value = 16'h0000;
        endcase
    end

    // Next-state logic for the whole block
    always_comb
    begin
        next_s = s;
        next_s.req = 1'b0;
        next_s.rvalid = 1'b0;
        if (reset)
        begin
            next_s = '0;
        end
        else
        begin
            // Frame parity for the alternate-frame cadence
            if (frame_end)
            begin
                next_s.parity = !s.parity;
                next_s.sample_count = sample_count;
                next_s.mean_level = mean_level;
            end
            // Frame start counts down the pending latencies and applies
            if (frame_start)
            begin
                if (s.exp_wait != 2'h0)
                begin
                    next_s.exp_wait = s.exp_wait - 2'h1;
                end
                if (s.gain_wait != 2'h0)
                begin
                    next_s.gain_wait = s.gain_wait - 2'h1;
                end
                if (s.exp_wait == 2'h1)
                begin
                    next_s.app_exposure = s.pend.exposure;
                end
                if (s.gain_wait == 2'h1)
                begin
                    next_s.app_first_amp = s.pend.first_amp;
                    next_s.app_second_amp = s.pend.second_amp;
                    next_s.app_fine = s.pend.fine_gain;
                end
                // Loop-independent settings follow the sequencer directly
                next_s.app_knee2 = seq_cfg.second_knee_exposure;
                next_s.app_knee3 = seq_cfg.third_knee_exposure;
                next_s.app_knee2_en = seq_cfg.two_knee_integration;
                next_s.app_knee3_en = seq_cfg.three_knee_integration;
                if (global_shutter)
                begin
                    next_s.app_step = seq_cfg.step_scaler;
                    next_s.app_clear = seq_cfg.array_clear_time;
                end
            end
            // New request at an evaluating frame end; a newer request wins
            if (eval_now)
            begin
                next_s.req = 1'b1;
                next_s.loop = loop_result;
                next_s.pend = loop_result;
                next_s.exp_wait = `ESM_EXP_LATENCY;
                next_s.gain_wait = s.gain_comp ? `ESM_EXP_LATENCY : `ESM_GAIN_LATENCY;
            end
            // Only the control words are writable; status writes are dropped
            if (reg_wr && reg_addr == `ESM_ADDR_PROBE_CTRL)
            begin
                next_s.probe_sel = reg_wdata[`ESM_PROBE_SEL_LSB +: 3];
            end
            if (reg_wr && reg_addr == `ESM_ADDR_GAIN_CTRL)
            begin
                next_s.gain_comp = reg_wdata[`ESM_GAIN_COMP_BIT];
            end
            if (reg_rd)
            begin
                next_s.rdata = read_value;
                next_s.rvalid = 1'b1;
            end
            // Probe routing
            case (s.probe_sel)
                `ESM_PROBE_OFF:
                begin
                    next_s.probe_a = 1'b0;
                    next_s.probe_b = 1'b0;
                end
                `ESM_PROBE_INT_ROW:
                begin
                    next_s.probe_a = seq_ind.integration_active;
                    next_s.probe_b = seq_ind.row_overhead_window;
                end
                `ESM_PROBE_INT_KNEE:
                begin
                    next_s.probe_a = seq_ind.integration_active;
                    next_s.probe_b = seq_ind.frame_overhead_window &&
                        (seq_cfg.two_knee_integration || seq_cfg.three_knee_integration);
                end
                `ESM_PROBE_COL_BLACK:
                begin
                    next_s.probe_a = seq_ind.col_readout_start;
                    next_s.probe_b = seq_ind.black_line;
                end
                `ESM_PROBE_FRAME_ROW:
                begin
                    next_s.probe_a = seq_ind.frame_start_ind;
                    next_s.probe_b = seq_ind.row_overhead_start;
                end
                `ESM_PROBE_LINE_ROW:
                begin
                    next_s.probe_a = seq_ind.first_line;
                    next_s.probe_b = seq_ind.row_overhead_start;
                end
                `ESM_PROBE_ROW_COL:
                begin
                    next_s.probe_a = seq_ind.row_overhead_window;
                    next_s.probe_b = seq_ind.col_readout_start;
                end
                `ESM_PROBE_COL_SPLIT:
                begin
                    next_s.probe_a = seq_ind.col_readout_start && seq_ind.black_line;
                    next_s.probe_b = seq_ind.col_readout_start && !seq_ind.black_line;
                end
                default:
                begin
                    next_s.probe_a = 1'b0;
                    next_s.probe_b = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clock)
    begin
        s <= next_s;
    end

    // Outputs straight from state
    assign reg_rdata = s.rdata;
    assign reg_rvalid = s.rvalid;
    assign exp_request = s.req;
    assign request_values = s.loop;
    assign probe_out_a = s.probe_a;
    assign probe_out_b = s.probe_b;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    // Checks on cadence, latency, status and probes
    a_alt_frame_skip: assert property (frame_end && !s.parity |=> !exp_request)
        else $error("request issued on a non-evaluating frame");
    a_alt_frame_eval: assert property (frame_end && s.parity |=> exp_request)
        else $error("evaluating frame end gave no request");
    a_loop_on_req: assert property (eval_now |=> request_values == $past(loop_result))
        else $error("loop status not refreshed with request");
    a_gain_comp_wait: assert property (eval_now && s.gain_comp |=> s.gain_wait == 2'h2)
        else $error("compensated gain latency wrong");
    a_gain_plain_wait: assert property (eval_now && !s.gain_comp |=> s.gain_wait == 2'h1)
        else $error("uncompensated gain latency wrong");
    a_exp_apply: assert property (frame_start && s.exp_wait == 2'h1 |=> s.app_exposure == $past(s.pend.exposure))
        else $error("exposure not applied at latency end");
    a_exp_hold_early: assert property (eval_now ##1 !frame_start |=> $stable(s.app_exposure))
        else $error("exposure applied before a frame start");
    a_stats_count: assert property (frame_end |=> s.sample_count == $past(sample_count))
        else $error("sample count not captured at frame end");
    a_stats_mean: assert property (frame_end |=> s.mean_level == $past(mean_level))
        else $error("mean level not captured at frame end");
    a_knee_hold: assert property (!frame_start |=> $stable(s.app_knee2) && $stable(s.app_knee3))
        else $error("knee exposure changed outside frame start");
    a_probe_off: assert property (s.probe_sel == 3'h0 |=> !probe_out_a && !probe_out_b)
        else $error("probes not low for code zero");
    a_probe_black: assert property (s.probe_sel == 3'h3 |=> probe_out_b == $past(seq_ind.black_line))
        else $error("black line probe wrong");
    a_ro_write: assert property (reg_wr && reg_addr == 9'h0d2 && !frame_start |=> $stable(s.app_exposure))
        else $error("status register changed by a write");
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    a_rvalid_pulse: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read valid without a read");
    a_read_exposure: assert property (reg_rd && reg_addr == 9'h0d2 |=> reg_rdata == $past(s.app_exposure))
        else $error("applied exposure read back wrong");
    a_status_write: assert property (reg_wr && reg_addr == 9'h0b8 && !frame_end |=> $stable(s.sample_count))
        else $error("sample count changed by a write");

    // Probe routing per selection code, one cycle behind the indications
    a_probe_int_row: assert property (s.probe_sel == 3'h1 |=>
        probe_out_a == $past(seq_ind.integration_active) && probe_out_b == $past(seq_ind.row_overhead_window))
        else $error("probe code one routed wrong");
    a_probe_int_knee: assert property (s.probe_sel == 3'h2 |=> probe_out_a == $past(seq_ind.integration_active))
        else $error("probe code two routed wrong");
    a_probe_knee_low: assert property (s.probe_sel == 3'h2 && !seq_ind.frame_overhead_window |=> !probe_out_b)
        else $error("knee probe high outside frame overhead");
    a_probe_col_start: assert property (s.probe_sel == 3'h3 |=> probe_out_a == $past(seq_ind.col_readout_start))
        else $error("probe code three routed wrong");
    a_probe_frame_row: assert property (s.probe_sel == 3'h4 |=>
        probe_out_a == $past(seq_ind.frame_start_ind) && probe_out_b == $past(seq_ind.row_overhead_start))
        else $error("probe code four routed wrong");
    a_probe_line_row: assert property (s.probe_sel == 3'h5 |=>
        probe_out_a == $past(seq_ind.first_line) && probe_out_b == $past(seq_ind.row_overhead_start))
        else $error("probe code five routed wrong");
    a_probe_row_col: assert property (s.probe_sel == 3'h6 |=>
        probe_out_a == $past(seq_ind.row_overhead_window) && probe_out_b == $past(seq_ind.col_readout_start))
        else $error("probe code six routed wrong");
    a_probe_split_low: assert property (s.probe_sel == 3'h7 && !seq_ind.col_readout_start |=>
        !probe_out_a && !probe_out_b)
        else $error("split probe high without column start");
    a_probe_sel_write: assert property (reg_wr && reg_addr == 9'h0c0 |=> s.probe_sel == $past(reg_wdata[13:11]))
        else $error("probe selection not written");

    // Applied values: capture at frame start, hold otherwise
    a_gain_apply: assert property (frame_start && s.gain_wait == 2'h1 |=> s.app_fine == $past(s.pend.fine_gain))
        else $error("fine gain not applied at latency end");
    a_amp_apply: assert property (frame_start && s.gain_wait == 2'h1 |=>
        s.app_first_amp == $past(s.pend.first_amp) && s.app_second_amp == $past(s.pend.second_amp))
        else $error("amp stages not applied at latency end");
    a_gain_hold: assert property (!frame_start |=> $stable(s.app_fine) && $stable(s.app_first_amp))
        else $error("applied gain changed outside frame start");
    a_exp_hold: assert property (!frame_start |=> $stable(s.app_exposure))
        else $error("applied exposure changed outside frame start");
    a_step_capture: assert property (frame_start && global_shutter |=> s.app_step == $past(seq_cfg.step_scaler))
        else $error("step scaler not captured");
    a_clear_capture: assert property (frame_start && global_shutter |=>
        s.app_clear == $past(seq_cfg.array_clear_time))
        else $error("array clear time not captured");
    a_step_hold: assert property (!(frame_start && global_shutter) |=> $stable(s.app_step) && $stable(s.app_clear))
        else $error("global shutter values changed without capture");
    a_knee_capture: assert property (frame_start |=> s.app_knee2 == $past(seq_cfg.second_knee_exposure) &&
        s.app_knee3 == $past(seq_cfg.third_knee_exposure))
        else $error("knee exposures not captured");
    a_knee_flags: assert property (frame_start |=> s.app_knee2_en == $past(seq_cfg.two_knee_integration) &&
        s.app_knee3_en == $past(seq_cfg.three_knee_integration))
        else $error("knee configurations not captured");
    a_knee_flag_hold: assert property (!frame_start |=> $stable(s.app_knee2_en) && $stable(s.app_knee3_en))
        else $error("knee configuration changed outside frame start");

    // Loop status and latency counters
    a_loop_hold: assert property (!eval_now |=> $stable(s.loop))
        else $error("loop status changed without evaluation");
    a_stats_hold: assert property (!frame_end |=> $stable(s.sample_count) && $stable(s.mean_level))
        else $error("statistics changed outside frame end");
    a_req_pulse: assert property (exp_request |=> !exp_request)
        else $error("request longer than one cycle");
    a_exp_count: assert property (frame_start && !eval_now && s.exp_wait != 2'h0 |=>
        s.exp_wait == $past(s.exp_wait) - 2'h1)
        else $error("exposure latency count wrong");
    a_gain_count: assert property (frame_start && !eval_now && s.gain_wait != 2'h0 |=>
        s.gain_wait == $past(s.gain_wait) - 2'h1)
        else $error("gain latency count wrong");
    a_gain_ctrl_write: assert property (reg_wr && reg_addr == 9'h0cc |=> s.gain_comp == $past(reg_wdata[13]))
        else $error("gain compensation bit not written");

    c_request: cover property (exp_request);
    c_comp_gain: cover property (s.gain_comp && frame_start && s.gain_wait == 2'h1);
    c_probe_split: cover property (s.probe_sel == 3'h7 && probe_out_a);
    c_global_step: cover property (frame_start && global_shutter);
    c_knee_probe: cover property (s.probe_sel == 3'h2 && probe_out_b);

endmodule
`default_nettype wire

// File: sim/esm_host.sv
// Host model that drives the configuration register port of the status block
`timescale 1ns/1ps
`default_nettype none

module esm_host (
    // Clock
    input wire logic clock,
    // Register port towards the block
    output logic [8:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    // Idle port from time zero
    initial
    begin
        reg_addr = 9'h000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end

    // One-cycle write strobe; released lines show inverted values
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // One-cycle read strobe; data only counts with the valid pulse
    task automatic rd(input logic [8:0] a, output logic [15:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rvalid ? reg_rdata : 16'hxxxx;
    endtask
endmodule

`default_nettype wire

// File: sim/esm_status_test.sv
// Self-checking testbench of the exposure status and probe block
`timescale 1ns/1ps
`default_nettype none
`include "esm_consts.svh"

module esm_status_test
    import esm_pkg::*;
;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic frame_start = 1'b0;
    logic frame_end = 1'b0;
    logic global_shutter = 1'b0;
    logic [15:0] sample_count = 16'h0321;
    logic [9:0] mean_level = 10'h2a5;
    esm_loop_s loop_result = {16'h1234, 2'h1, 2'h3, 12'habc};
    esm_seq_cfg_s seq_cfg = {16'h1111, 16'h2222, 16'h3333, 16'h4444, 1'b1, 1'b0};
    esm_seq_ind_s seq_ind = 8'h00;
    logic [8:0] reg_addr;
    logic reg_wr, reg_rd, reg_rvalid, exp_request, probe_out_a, probe_out_b;
    logic [15:0] reg_wdata, reg_rdata;
    esm_loop_s request_values;
    int fails = 0;
    int n_compared = 0;
    logic [7:0] pat [4] = '{8'ha5, 8'h5a, 8'hf0, 8'h0f};

    esm_status u_esm_status (.clock(clock), .reset(reset), .frame_start(frame_start), .frame_end(frame_end),
        .global_shutter(global_shutter), .sample_count(sample_count), .mean_level(mean_level),
        .loop_result(loop_result), .seq_cfg(seq_cfg), .seq_ind(seq_ind), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .exp_request(exp_request), .request_values(request_values),
        .probe_out_a(probe_out_a), .probe_out_b(probe_out_b));

    esm_host u_esm_host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    // Clock
    always #5 clock = ~clock;

    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Read a register and compare
    task automatic rdc(input logic [8:0] a, input logic [15:0] e);
        logic [15:0] d;
        u_esm_host.rd(a, d);
        chk(d, e);
    endtask

    // One-cycle frame end or frame start pulse
    task automatic frame(input logic fe);
        @(negedge clock);
        frame_end = fe;
        frame_start = ~fe;
        @(negedge clock);
        frame_end = 1'b0;
        frame_start = 1'b0;
    endtask

    // Expected probe pair for a selection code
    function automatic logic [1:0] pexp(input logic [2:0] s, input esm_seq_ind_s i, input logic k);
        case (s)
            3'h0: return 2'b00;
            3'h1: return {i.integration_active, i.row_overhead_window};
            3'h2: return {i.integration_active, i.frame_overhead_window & k};
            3'h3: return {i.col_readout_start, i.black_line};
            3'h4: return {i.frame_start_ind, i.row_overhead_start};
            3'h5: return {i.first_line, i.row_overhead_start};
            3'h6: return {i.row_overhead_window, i.col_readout_start};
            default: return {i.col_readout_start & i.black_line, i.col_readout_start & ~i.black_line};
        endcase
    endfunction

    // Counts and verdict
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        repeat (5000) @(posedge clock);
        fails++;
        end_of_test();
    end

    // Test sequence
    initial
    begin
        repeat (5) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        rdc(`ESM_ADDR_APP_EXPOSURE, 16'h0000);
        rdc(9'h000, 16'h0000);
        // First frame end only gathers statistics
        frame(1'b1);
        chk({15'h0, exp_request}, 16'h0000);
        rdc(`ESM_ADDR_SAMPLE_COUNT, 16'h0321);
        rdc(`ESM_ADDR_MEAN_LEVEL, 16'h02a5);
        rdc(`ESM_ADDR_LOOP_EXPOSURE, 16'h0000);
        // Second frame end evaluates and requests
        frame(1'b1);
        chk({15'h0, exp_request}, 16'h0001);
        chk(request_values[31:16], 16'h1234);
        chk(request_values[15:0], 16'h7abc);
        rdc(`ESM_ADDR_LOOP_EXPOSURE, 16'h1234);
        rdc(`ESM_ADDR_LOOP_AMP, 16'habcd);
        rdc(`ESM_ADDR_APP_EXPOSURE, 16'h0000);
        // First frame start applies gain and captures settings
        global_shutter = 1'b1;
        frame(1'b0);
        global_shutter = 1'b0;
        seq_cfg.step_scaler = 16'h5555;
        rdc(`ESM_ADDR_APP_FINE, 16'h1abc);
        rdc(`ESM_ADDR_APP_AMP, 16'h0061);
        rdc(`ESM_ADDR_APP_EXPOSURE, 16'h0000);
        rdc(`ESM_ADDR_APP_CLEAR, 16'h2222);
        rdc(`ESM_ADDR_APP_KNEE2, 16'h3333);
        rdc(`ESM_ADDR_APP_KNEE3, 16'h4444);
        // Second frame start applies exposure; step scaler holds
        frame(1'b0);
        rdc(`ESM_ADDR_APP_EXPOSURE, 16'h1234);
        rdc(`ESM_ADDR_APP_STEP, 16'h1111);
        u_esm_host.wr(`ESM_ADDR_APP_EXPOSURE, 16'hffff);
        rdc(`ESM_ADDR_APP_EXPOSURE, 16'h1234);
        $display("test loop and applied status done");
        // Gain latency compensation set by the host
        u_esm_host.wr(`ESM_ADDR_GAIN_CTRL, 16'h2000);
        rdc(`ESM_ADDR_GAIN_CTRL, 16'h2000);
        loop_result = {16'h0777, 2'h0, 2'h2, 12'h123};
        frame(1'b1);
        chk({15'h0, exp_request}, 16'h0000);
        frame(1'b1);
        chk({15'h0, exp_request}, 16'h0001);
        frame(1'b0);
        rdc(`ESM_ADDR_APP_FINE, 16'h1abc);
        frame(1'b0);
        rdc(`ESM_ADDR_APP_FINE, 16'h1123);
        rdc(`ESM_ADDR_APP_EXPOSURE, 16'h0777);
        $display("test gain compensation done");
        // Every probe code against several indication patterns
        for (int s = 0; s < 8; s++)
        begin
            u_esm_host.wr(`ESM_ADDR_PROBE_CTRL, 16'(s) << 11);
            rdc(`ESM_ADDR_PROBE_CTRL, 16'(s) << 11);
            for (int j = 0; j < 4; j++)
            begin
                @(negedge clock);
                seq_ind = pat[j];
                seq_cfg.two_knee_integration = j[0];
                @(negedge clock);
                chk({14'h0, probe_out_a, probe_out_b}, {14'h0, pexp(3'(s), pat[j], j[0])});
            end
        end
        $display("test probe selection done");
        end_of_test();
    end
endmodule

`default_nettype wire
